// ==== hw/pmul_params.svh ====
`ifndef PMUL_PARAMS_SVH
`define PMUL_PARAMS_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define PMUL_W          16
`define PMUL_AW         12
`define PMUL_DW         32

// ****************************************************************
// Register offsets (byte addresses, one word each)
// ****************************************************************
`define PMUL_OFS_STROBE   12'h000
`define PMUL_OFS_PRODUCT  12'h004
`define PMUL_OFS_OPERANDS 12'h008
`define PMUL_OFS_MODES    12'h00C

// ****************************************************************
// Software strobe fields
// ****************************************************************
`define PMUL_STB_X      0
`define PMUL_STB_Y      1
`define PMUL_STB_LOW    2
`define PMUL_STB_HIGH   3
`define PMUL_STB_W      4

// ****************************************************************
// Arithmetic constants
// ****************************************************************
`define PMUL_RND_HI     32'h0000_8000
`define PMUL_RND_LO     32'h0000_4000
`define PMUL_MOST_NEG   16'h8000
`define PMUL_OVF_FRAC   32'h8000_0000

// ****************************************************************
// Bus answers
// ****************************************************************
`define PMUL_RESP_OKAY   2'h0
`define PMUL_RESP_SLVERR 2'h2

`endif

// ==== hw/pmul_pkg.sv ====
`include "pmul_params.svh"

package pmul_pkg;

  // ****************************************************************
  // Pin bundle, one field per device pin input
  // ****************************************************************
  typedef struct packed {
    logic [`PMUL_W-1:0] x_data;
    logic [`PMUL_W-1:0] y_data;
    logic               x_operand_clock;
    logic               y_operand_clock;
    logic               high_product_clock;
    logic               low_product_clock;
    logic               x_sign_mode;
    logic               y_sign_mode;
    logic               round_request;
    logic               format_adjust;
    logic               output_bypass;
    logic               high_half_select_n;
    logic               low_half_port_enable_n;
    logic               product_port_enable_n;
  } pmul_pins_s;

  // ****************************************************************
  // AXI4-Lite carriers
  // ****************************************************************
  typedef struct packed {
    logic [`PMUL_AW-1:0] awaddr;
    logic                awvalid;
    logic [`PMUL_DW-1:0] wdata;
    logic [3:0]          wstrb;
    logic                wvalid;
    logic                bready;
    logic [`PMUL_AW-1:0] araddr;
    logic                arvalid;
    logic                rready;
  } pmul_axil_req_s;

  typedef struct packed {
    logic                awready;
    logic                wready;
    logic [1:0]          bresp;
    logic                bvalid;
    logic                arready;
    logic [`PMUL_DW-1:0] rdata;
    logic [1:0]          rresp;
    logic                rvalid;
  } pmul_axil_rsp_s;

  // ****************************************************************
  // Whole state of the multiplier top
  // ****************************************************************
  typedef struct packed {
    logic [`PMUL_W-1:0]   x_q;
    logic [`PMUL_W-1:0]   y_q;
    logic                 xs_q;
    logic                 ys_q;
    logic                 rnd_q;
    logic [`PMUL_W-1:0]   msp_q;
    logic [`PMUL_W-1:0]   lsp_q;
    logic [3:0]           clk_prev;
    logic [`PMUL_STB_W-1:0] stb;
    logic [`PMUL_W-1:0]   prod_out;
    logic                 prod_oe;
    logic [`PMUL_W-1:0]   y_out;
    logic                 y_oe;
    logic                 aw_got;
    logic                 w_got;
    logic [`PMUL_AW-1:0]  awaddr;
    logic [`PMUL_DW-1:0]  wdata;
    logic                 wstrb0;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [`PMUL_DW-1:0]  rdata;
    logic [1:0]           rresp;
  } pmul_state_s;

endpackage

// ==== hw/pmul_sync.sv ====
`timescale 1ns/1ps

// ****************************************************************
// Three-stage pin synchroniser with agreement filter
// ****************************************************************
module pmul_sync #(
  parameter int unsigned    W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] stable_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] stable;
  } pmul_sync_state_s;

  pmul_sync_state_s st;
  pmul_sync_state_s nx;

  // Stage one feeds only stage two; a bit moves once two and three agree
  always_comb begin
    nx        = st;
    nx.s1     = async_i;
    nx.s2     = st.s1;
    nx.s3     = st.s2;
    nx.stable = (st.s3 & ~(st.s2 ^ st.s3)) | (st.stable & (st.s2 ^ st.s3));
  end

  // Reset to the idle pin levels so enables stay off
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, stable: RST_VAL};
    end else begin
      st <= nx;
    end
  end

  assign stable_o = st.stable;

endmodule

// ==== hw/pmul_top.sv ====
`timescale 1ns/1ps
`include "pmul_params.svh"

module pmul_top (
  input  wire logic                    mclk_i,
  input  wire logic                    rst_i,
  input  wire logic [`PMUL_W-1:0]      x_data_i,
  input  wire logic [`PMUL_W-1:0]      y_data_i,
  output logic      [`PMUL_W-1:0]      y_data_o,
  output logic                         y_data_oe_o,
  output logic      [`PMUL_W-1:0]      product_o,
  output logic                         product_oe_o,
  input  wire logic                    x_operand_clock_i,
  input  wire logic                    y_operand_clock_i,
  input  wire logic                    high_product_clock_i,
  input  wire logic                    low_product_clock_i,
  input  wire logic                    x_sign_mode_i,
  input  wire logic                    y_sign_mode_i,
  input  wire logic                    round_request_i,
  input  wire logic                    format_adjust_i,
  input  wire logic                    output_bypass_i,
  input  wire logic                    high_half_select_n_i,
  input  wire logic                    low_half_port_enable_n_i,
  input  wire logic                    product_port_enable_n_i,
  input  wire pmul_pkg::pmul_axil_req_s axi_req_i,
  output pmul_pkg::pmul_axil_rsp_s      axi_rsp_o
);

  localparam int unsigned PW = $bits(pmul_pkg::pmul_pins_s);

  // ****************************************************************
  // Pin capture
  // ****************************************************************
  // Idle levels: enables released so nothing is driven out of reset
  localparam pmul_pkg::pmul_pins_s PIN_IDLE = '{
    x_data: '0, y_data: '0,
    x_operand_clock: 1'b0, y_operand_clock: 1'b0,
    high_product_clock: 1'b0, low_product_clock: 1'b0,
    x_sign_mode: 1'b0, y_sign_mode: 1'b0, round_request: 1'b0,
    format_adjust: 1'b1, output_bypass: 1'b0,
    high_half_select_n: 1'b0, low_half_port_enable_n: 1'b1,
    product_port_enable_n: 1'b1
  };

  pmul_pkg::pmul_pins_s pin_raw;
  pmul_pkg::pmul_pins_s pin;
  logic [PW-1:0]        pin_stable;

  // Data and clocks share one path so data keeps its place next to its edge
  always_comb begin
    pin_raw                        = PIN_IDLE;
    pin_raw.x_data                 = x_data_i;
    pin_raw.y_data                 = y_data_i;
    pin_raw.x_operand_clock        = x_operand_clock_i;
    pin_raw.y_operand_clock        = y_operand_clock_i;
    pin_raw.high_product_clock     = high_product_clock_i;
    pin_raw.low_product_clock      = low_product_clock_i;
    pin_raw.x_sign_mode            = x_sign_mode_i;
    pin_raw.y_sign_mode            = y_sign_mode_i;
    pin_raw.round_request          = round_request_i;
    pin_raw.format_adjust          = format_adjust_i;
    pin_raw.output_bypass          = output_bypass_i;
    pin_raw.high_half_select_n     = high_half_select_n_i;
    pin_raw.low_half_port_enable_n = low_half_port_enable_n_i;
    pin_raw.product_port_enable_n  = product_port_enable_n_i;
  end

  pmul_sync #(
    .W       (PW),
    .RST_VAL (PIN_IDLE)
  ) u_sync (
    .mclk_i   (mclk_i),
    .rst_i    (rst_i),
    .async_i  (pin_raw),
    .stable_o (pin_stable)
  );

  assign pin = pmul_pkg::pmul_pins_s'(pin_stable);

  // ****************************************************************
  // State and derived terms
  // ****************************************************************
  pmul_pkg::pmul_state_s st;
  pmul_pkg::pmul_state_s nx;

  logic [3:0]             clk_now;
  logic [3:0]             clk_rise;
  logic                   x_load;
  logic                   y_load;
  logic                   low_load;
  logic                   high_load;
  logic signed [`PMUL_W:0]   x_ext;
  logic signed [`PMUL_W:0]   y_ext;
  logic signed [2*`PMUL_W+1:0] full;
  logic [2*`PMUL_W-1:0]   raw;
  logic [2*`PMUL_W-1:0]   rnd_inc;
  logic [2*`PMUL_W-1:0]   rounded;
  logic [2*`PMUL_W-1:0]   fmt;
  logic [`PMUL_W-1:0]     msp_view;
  logic [`PMUL_W-1:0]     lsp_view;

  // Order: x, y, low, high
  assign clk_now = {pin.high_product_clock, pin.low_product_clock,
                    pin.y_operand_clock, pin.x_operand_clock};
  assign clk_rise = clk_now & ~st.clk_prev;

  // Pin edges and software strobes both count as clock events
  assign x_load    = clk_rise[`PMUL_STB_X] | st.stb[`PMUL_STB_X];
  assign y_load    = clk_rise[`PMUL_STB_Y] | st.stb[`PMUL_STB_Y];
  assign low_load  = clk_rise[`PMUL_STB_LOW] | st.stb[`PMUL_STB_LOW];
  assign high_load = clk_rise[`PMUL_STB_HIGH] | st.stb[`PMUL_STB_HIGH];

  // ****************************************************************
  // Multiplier array
  // ****************************************************************
  // A sign bit extends only a two's complement operand; mixed falls out
  assign x_ext = $signed({st.xs_q & st.x_q[`PMUL_W-1], st.x_q});
  assign y_ext = $signed({st.ys_q & st.y_q[`PMUL_W-1], st.y_q});
  assign full  = x_ext * y_ext;
  assign raw   = full[2*`PMUL_W-1:0];

  // Rounding only ever adds, so a bias toward plus is accepted
  assign rnd_inc = !st.rnd_q ? '0 :
                   (pin.format_adjust ? `PMUL_RND_HI : `PMUL_RND_LO);
  assign rounded = raw + rnd_inc;

  // Shifted format drops the redundant sign and repeats it in the low half;
  // the most negative square is not trapped and reads back as minus one
  assign fmt = pin.format_adjust ? rounded :
               {rounded[2*`PMUL_W-2:`PMUL_W-1], rounded[2*`PMUL_W-1],
                rounded[`PMUL_W-2:0]};

  // Bypass shows the live product instead of the held halves
  assign msp_view = pin.output_bypass ? fmt[2*`PMUL_W-1:`PMUL_W] : st.msp_q;
  assign lsp_view = pin.output_bypass ? fmt[`PMUL_W-1:0] : st.lsp_q;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  logic                 aw_hs;
  logic                 w_hs;
  logic                 aw_now;
  logic                 w_now;
  logic [`PMUL_AW-1:0]  wr_addr;
  logic [`PMUL_AW-1:0]  wr_word;
  logic [`PMUL_AW-1:0]  rd_word;

  assign aw_hs   = axi_req_i.awvalid & axi_rsp_o.awready;
  assign w_hs    = axi_req_i.wvalid & axi_rsp_o.wready;
  assign aw_now  = st.aw_got | aw_hs;
  assign w_now   = st.w_got | w_hs;
  assign wr_addr = st.aw_got ? st.awaddr : axi_req_i.awaddr;
  assign wr_word = {wr_addr[`PMUL_AW-1:2], 2'b00};
  assign rd_word = {axi_req_i.araddr[`PMUL_AW-1:2], 2'b00};

  always_comb begin
    nx          = st;
    nx.clk_prev = clk_now;
    nx.stb      = '0;

    // Operand, sign mode and round registers follow their operand clocks
    if (x_load) begin
      nx.x_q  = pin.x_data;
      nx.xs_q = pin.x_sign_mode;
    end
    if (y_load) begin
      nx.y_q  = pin.y_data;
      nx.ys_q = pin.y_sign_mode;
    end
    if (x_load || y_load) begin
      nx.rnd_q = pin.round_request;
    end

    // Output halves each on their own product clock
    if (low_load) begin
      nx.lsp_q = fmt[`PMUL_W-1:0];
    end
    if (high_load) begin
      nx.msp_q = fmt[2*`PMUL_W-1:`PMUL_W];
    end

    // Output pins registered so the pads see no glitching mux
    nx.prod_out = pin.high_half_select_n ? lsp_view : msp_view;
    nx.prod_oe  = !pin.product_port_enable_n;
    nx.y_out    = lsp_view;
    nx.y_oe     = !pin.low_half_port_enable_n;

    // Write channel: address and data taken in either order
    if (aw_hs) begin
      nx.aw_got = 1'b1;
      nx.awaddr = axi_req_i.awaddr;
    end
    if (w_hs) begin
      nx.w_got  = 1'b1;
      nx.wdata  = axi_req_i.wdata;
      nx.wstrb0 = axi_req_i.wstrb[0];
    end
    if (aw_now && w_now && !st.bvalid) begin
      nx.aw_got = 1'b0;
      nx.w_got  = 1'b0;
      nx.bvalid = 1'b1;
      nx.bresp  = `PMUL_RESP_OKAY;
      if (wr_word == `PMUL_OFS_STROBE) begin
        if (st.w_got ? st.wstrb0 : axi_req_i.wstrb[0]) begin
          nx.stb = st.w_got ? st.wdata[`PMUL_STB_W-1:0]
                            : axi_req_i.wdata[`PMUL_STB_W-1:0];
        end
      end else if (wr_word != `PMUL_OFS_PRODUCT && wr_word != `PMUL_OFS_OPERANDS &&
                   wr_word != `PMUL_OFS_MODES) begin
        nx.bresp = `PMUL_RESP_SLVERR;
      end
    end else if (st.bvalid && axi_req_i.bready) begin
      nx.bvalid = 1'b0;
    end

    // Read channel: one read at a time, data held until taken
    if (!st.rvalid && axi_req_i.arvalid) begin
      nx.rvalid = 1'b1;
      nx.rresp  = `PMUL_RESP_OKAY;
      case (rd_word)
        `PMUL_OFS_STROBE:   nx.rdata = '0;
        `PMUL_OFS_PRODUCT:  nx.rdata = {msp_view, lsp_view};
        `PMUL_OFS_OPERANDS: nx.rdata = {st.y_q, st.x_q};
        `PMUL_OFS_MODES: begin
          nx.rdata = '0;
          nx.rdata[4:0] = {pin.output_bypass, pin.format_adjust, st.rnd_q,
                           st.ys_q, st.xs_q};
        end
        default: begin
          nx.rdata = '0;
          nx.rresp = `PMUL_RESP_SLVERR;
        end
      endcase
    end else if (st.rvalid && axi_req_i.rready) begin
      nx.rvalid = 1'b0;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Everything clears; the enables come up released
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign product_o    = st.prod_out;
  assign product_oe_o = st.prod_oe;
  assign y_data_o     = st.y_out;
  assign y_data_oe_o  = st.y_oe;

  // Ready terms combinational so a channel can move on its first cycle
  always_comb begin
    axi_rsp_o         = '0;
    axi_rsp_o.awready = !st.aw_got && !st.bvalid;
    axi_rsp_o.wready  = !st.w_got && !st.bvalid;
    axi_rsp_o.bvalid  = st.bvalid;
    axi_rsp_o.bresp   = st.bresp;
    axi_rsp_o.arready = !st.rvalid;
    axi_rsp_o.rvalid  = st.rvalid;
    axi_rsp_o.rdata   = st.rdata;
    axi_rsp_o.rresp   = st.rresp;
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  x_operand_load_a: assert property (
    x_load |=> (st.x_q == $past(pin.x_data)) && (st.xs_q == $past(pin.x_sign_mode)))
    else $error("x operand not loaded on its clock");

  y_operand_load_a: assert property (
    y_load |=> st.y_q == $past(pin.y_data))
    else $error("y operand not loaded on its clock");

  sign_mode_hold_a: assert property (
    !y_load |=> $stable(st.ys_q))
    else $error("y sign mode changed without its clock");

  round_capture_a: assert property (
    (x_load || y_load) |=> st.rnd_q == $past(pin.round_request))
    else $error("round request not captured on operand clock");

  low_half_hold_a: assert property (
    !low_load |=> st.lsp_q == $past(st.lsp_q))
    else $error("low half changed without its clock");

  unsigned_product_a: assert property (
    (!st.xs_q && !st.ys_q) |-> raw == (32'(st.x_q) * 32'(st.y_q)))
    else $error("unsigned product wrong");

  round_bit_a: assert property (
    (st.rnd_q && !pin.format_adjust) |-> rounded == raw + `PMUL_RND_LO)
    else $error("round increment at wrong bit");

  overflow_case_a: assert property (
    (st.xs_q && st.ys_q && !st.rnd_q && !pin.format_adjust &&
     st.x_q == `PMUL_MOST_NEG && st.y_q == `PMUL_MOST_NEG) |-> fmt == `PMUL_OVF_FRAC)
    else $error("most negative square not minus one");

  product_mux_a: assert property (
    ##1 product_o == ($past(pin.high_half_select_n) ? $past(lsp_view) : $past(msp_view)))
    else $error("product port shows wrong half");

  shared_port_dir_a: assert property (
    ##1 (y_data_oe_o == !$past(pin.low_half_port_enable_n)) &&
        (y_data_o == $past(lsp_view)))
    else $error("shared port direction or data wrong");

  product_enable_a: assert property (
    ##1 product_oe_o == !$past(pin.product_port_enable_n))
    else $error("product port enable wrong");

endmodule

// ==== bench/pmul_host.sv ====
`timescale 1ns/1ps
`include "pmul_params.svh"

// ****************************************************************
// Host datapath model driving the multiplier pins
// ****************************************************************
module pmul_host (
  input  wire logic               mclk_i,
  output pmul_pkg::pmul_pins_s    pins_o,
  output logic      [`PMUL_W-1:0] y_drv_o
);
  pmul_pkg::pmul_pins_s p;

  assign pins_o = p;
  // While the device port is enabled the host side shows the inverse, never a stale copy that could pass by luck
  assign y_drv_o = p.low_half_port_enable_n ? p.y_data : ~p.y_data;

  // Idle levels from time zero: both ports floated
  initial begin
    p = '0;
    p.low_half_port_enable_n = 1'b1;
    p.product_port_enable_n = 1'b1;
    p.format_adjust = 1'b1;
  end

  // Static controls, then time for the pin synchroniser to settle
  task automatic ctl(input logic byp, input logic sel_n, input logic oel_n, input logic oep_n);
    @(posedge mclk_i);
    p.output_bypass <= byp;
    p.high_half_select_n <= sel_n;
    p.low_half_port_enable_n <= oel_n;
    p.product_port_enable_n <= oep_n;
    repeat (12) @(posedge mclk_i);
  endtask

  // Operands held well around the clock edge, since they cross a synchroniser
  task automatic put(input logic [15:0] x, input logic [15:0] y, input logic xs,
                     input logic ys, input logic rnd, input logic fa);
    @(posedge mclk_i);
    p.x_data <= x;
    p.y_data <= y;
    p.x_sign_mode <= xs;
    p.y_sign_mode <= ys;
    p.round_request <= rnd;
    p.format_adjust <= fa;
    repeat (5) @(posedge mclk_i);
    p.x_operand_clock <= 1'b1;
    p.y_operand_clock <= 1'b1;
    repeat (5) @(posedge mclk_i);
    p.x_operand_clock <= 1'b0;
    p.y_operand_clock <= 1'b0;
    repeat (5) @(posedge mclk_i);
    // Modes move after capture; only the captured copies may count
    p.x_sign_mode <= ~xs;
    p.y_sign_mode <= ~ys;
    p.round_request <= ~rnd;
    repeat (8) @(posedge mclk_i);
  endtask

  // Both product clocks pulsed together
  task automatic outclk();
    @(posedge mclk_i);
    p.high_product_clock <= 1'b1;
    p.low_product_clock <= 1'b1;
    repeat (5) @(posedge mclk_i);
    p.high_product_clock <= 1'b0;
    p.low_product_clock <= 1'b0;
    repeat (8) @(posedge mclk_i);
  endtask
endmodule

// ==== bench/pmul_top_tb.sv ====
`timescale 1ns/1ps
`include "pmul_params.svh"

module pmul_top_tb;
  logic                     mclk_i;
  logic                     rst_i;
  pmul_pkg::pmul_pins_s     pins;
  pmul_pkg::pmul_axil_req_s req;
  pmul_pkg::pmul_axil_rsp_s rsp;
  logic [15:0]              y_drv;
  logic [15:0]              y_out;
  logic [15:0]              y_wire;
  logic [15:0]              prod;
  logic                     y_oe;
  logic                     prod_oe;
  int                       err_count;
  int                       checked;
  logic [31:0]              rd;
  logic [31:0]              prev;
  logic [31:0]              e;
  logic [1:0]               rs;
  logic [35:0]              cases [8];

  // Shared pin level: device wins while enabled, else the host side
  assign y_wire = y_oe ? y_out : y_drv;

  pmul_host host (.mclk_i(mclk_i), .pins_o(pins), .y_drv_o(y_drv));

  pmul_top dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .x_data_i(pins.x_data), .y_data_i(y_wire),
    .y_data_o(y_out), .y_data_oe_o(y_oe), .product_o(prod), .product_oe_o(prod_oe),
    .x_operand_clock_i(pins.x_operand_clock), .y_operand_clock_i(pins.y_operand_clock),
    .high_product_clock_i(pins.high_product_clock),
    .low_product_clock_i(pins.low_product_clock),
    .x_sign_mode_i(pins.x_sign_mode), .y_sign_mode_i(pins.y_sign_mode),
    .round_request_i(pins.round_request), .format_adjust_i(pins.format_adjust),
    .output_bypass_i(pins.output_bypass), .high_half_select_n_i(pins.high_half_select_n),
    .low_half_port_enable_n_i(pins.low_half_port_enable_n),
    .product_port_enable_n_i(pins.product_port_enable_n), .axi_req_i(req), .axi_rsp_o(rsp)
  );

  // 200 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  // ****************************************************************
  // Checking and bus tasks
  // ****************************************************************
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask

  // Full product from the rules; shifted form replicates the sign into the low half
  function automatic logic [31:0] expp(input logic [15:0] x, input logic [15:0] y,
                                       input logic xs, input logic ys, input logic rnd,
                                       input logic fa);
    logic signed [33:0] a;
    logic signed [33:0] b;
    logic [31:0]        r;
    a = xs ? {{18{x[15]}}, x} : {18'h0, x};
    b = ys ? {{18{y[15]}}, y} : {18'h0, y};
    r = 32'(a * b) + (rnd ? (fa ? `PMUL_RND_HI : `PMUL_RND_LO) : 32'h0);
    return fa ? r : {r[30:15], r[31], r[14:0]};
  endfunction

  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int         n;
    logic       aw_t;
    logic       w_t;
    logic       b_t;
    logic [1:0] br;
    @(posedge mclk_i);
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      // Answer read mid-cycle, where it is settled for the coming edge
      @(negedge mclk_i);
      aw_t = req.awvalid && rsp.awready;
      w_t  = req.wvalid && rsp.wready;
      b_t  = rsp.bvalid;
      br   = rsp.bresp;
      @(posedge mclk_i);
      if (aw_t) req.awvalid <= 1'b0;
      if (w_t) req.wvalid <= 1'b0;
      if (b_t) begin
        req.bready <= 1'b0;
        chk("write response", {30'h0, er}, {30'h0, br});
        return;
      end
    end
    $display("unexpected write wait expected %h seen %h", 1'b1, 1'b0);
    err_count++;
    summarize();
  endtask

  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int   n;
    logic ar_t;
    logic r_t;
    @(posedge mclk_i);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      // Data taken mid-cycle while rvalid stands, released after the edge
      @(negedge mclk_i);
      ar_t = req.arvalid && rsp.arready;
      r_t  = rsp.rvalid;
      d    = rsp.rdata;
      r    = rsp.rresp;
      @(posedge mclk_i);
      if (ar_t) req.arvalid <= 1'b0;
      if (r_t) begin
        req.rready <= 1'b0;
        return;
      end
    end
    $display("unexpected read wait expected %h seen %h", 1'b1, 1'b0);
    err_count++;
    summarize();
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [15:0] x;
    logic [15:0] y;
    logic [3:0]  m;
    // Operand pair, then {x sign, y sign, round, format adjust}
    cases = '{{16'hFFFF, 16'hFFFF, 4'b0001}, {16'h8001, 16'h7FFF, 4'b1101},
              {16'hFFFF, 16'hFFFF, 4'b1001}, {16'h1234, 16'hF00D, 4'b0101},
              {16'h1234, 16'h5678, 4'b1111}, {16'h1234, 16'h5678, 4'b1110},
              {16'h8000, 16'h8000, 4'b1100}, {16'h8000, 16'h8000, 4'b1101}};
    err_count = 0;
    checked = 0;
    prev = 32'h0;
    req = '0;
    rst_i = 1'b1;
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    host.ctl(1'b0, 1'b0, 1'b1, 1'b0);
    for (int i = 0; i < 8; i++) begin
      {x, y, m} = cases[i];
      e = expp(x, y, m[3], m[2], m[1], m[0]);
      host.put(x, y, m[3], m[2], m[1], m[0]);
      axr(`PMUL_OFS_PRODUCT, rd, rs);
      chk("held product", prev, rd);
      host.outclk();
      axr(`PMUL_OFS_PRODUCT, rd, rs);
      chk("product", e, rd);
      chk("high half port", {16'h0, e[31:16]}, {16'h0, prod});
      chk("product enable", 32'h1, {31'h0, prod_oe});
      host.ctl(1'b0, 1'b1, 1'b0, 1'b0);
      chk("low half port", {16'h0, e[15:0]}, {16'h0, prod});
      chk("shared port", {16'h0, e[15:0]}, {16'h0, y_wire});
      chk("shared enable", 32'h1, {31'h0, y_oe});
      host.ctl(1'b0, 1'b0, 1'b1, 1'b0);
      chk("shared release", 32'h0, {31'h0, y_oe});
      prev = e;
    end
    $display("product cases done");
    host.ctl(1'b1, 1'b0, 1'b1, 1'b0);
    host.put(16'h0003, 16'h0005, 1'b0, 1'b0, 1'b0, 1'b1);
    axr(`PMUL_OFS_PRODUCT, rd, rs);
    chk("bypass product", 32'h0000_000F, rd);
    host.ctl(1'b0, 1'b0, 1'b1, 1'b1);
    chk("product float", 32'h0, {31'h0, prod_oe});
    axr(`PMUL_OFS_PRODUCT, rd, rs);
    chk("registered product", prev, rd);
    $display("bypass test done");
    axw(`PMUL_OFS_STROBE, 32'h0000_000C, `PMUL_RESP_OKAY);
    axr(`PMUL_OFS_PRODUCT, rd, rs);
    chk("strobed product", 32'h0000_000F, rd);
    axw(`PMUL_OFS_PRODUCT, 32'h0, `PMUL_RESP_OKAY);
    axr(`PMUL_OFS_PRODUCT, rd, rs);
    chk("read-only product", 32'h0000_000F, rd);
    axw(12'h010, 32'h1, `PMUL_RESP_SLVERR);
    axr(12'h010, rd, rs);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped response", {30'h0, `PMUL_RESP_SLVERR}, {30'h0, rs});
    axr(`PMUL_OFS_OPERANDS, rd, rs);
    chk("operands", 32'h0005_0003, rd);
    // Software loads of both operands pick up the flipped modes and round
    axw(`PMUL_OFS_STROBE, 32'h0000_0003, `PMUL_RESP_OKAY);
    axr(`PMUL_OFS_MODES, rd, rs);
    chk("modes", 32'h0000_000F, rd);
    $display("register test done");
    summarize();
  end
endmodule
